// *** rtl/pio_pkg.sv ***
// Constants, register map and carrier types for the I/O cell output path.
package pio_pkg;

   // Register map, byte addresses on the APB slave.
   localparam logic [11:0] PIO_CTRL_OFS   = 12'h000;
   localparam logic [11:0] PIO_STAT_OFS   = 12'h004;
   localparam logic [31:0] PIO_CTRL_RST   = 32'h0000_0000;
   localparam int          PIO_ADDR_W     = 12;

   // Number of routing clocks offered to the cell and strobe delay taps.
   localparam int          PIO_RCLK_N     = 4;
   localparam int          PIO_RSEL_W     = 2;
   localparam int          PIO_DLY_N      = 8;
   localparam int          PIO_DLY_W      = 3;

   // This cell is one of the few that own a strobe pad.
   localparam logic        PIO_STRB_AVAIL = 1'b1;

   // Control register width; the struct below lays out its fields.
   localparam int          PIO_CFG_W      = 11;

   // Status register bit positions.
   localparam int          PIO_ST_PAD     = 0;
   localparam int          PIO_ST_CCLK    = 1;
   localparam int          PIO_ST_FIRST   = 2;
   localparam int          PIO_ST_SECOND  = 3;
   localparam int          PIO_ST_GTS     = 4;
   localparam int          PIO_ST_CE      = 5;
   localparam int          PIO_ST_LSR     = 6;

   // Control register fields; bit 0 is the last member.
   typedef struct packed {
      logic [PIO_DLY_W-1:0]  strb_dly;   // Bits 10:8, strobe delay tap.
      logic                  lsr_inv;    // Bit 7, invert local reset.
      logic                  ce_inv;     // Bit 6, invert clock enable.
      logic                  clk_inv;    // Bit 5, invert cell clock.
      logic                  src_strb;   // Bit 4, clock from strobe.
      logic [PIO_RSEL_W-1:0] rclk_sel;   // Bits 3:2, routing clock index.
      logic                  sdr_latch;  // Bit 1, SDR element is a latch.
      logic                  ddr;        // Bit 0, double data rate.
   } pio_cfg_t;

   // Control signals as the cell registers see them.
   typedef struct packed {
      logic cell_clk;
      logic cell_ce;
      logic cell_lsr;
      logic gts;
   } pio_ctl_t;

endpackage

// *** rtl/pio_strb_dly.sv ***
// Tapped delay line that the strobe passes before the cell clock mux.
`timescale 1ns/1ps
module pio_strb_dly
   import pio_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 strb_in,
   input  wire logic [PIO_DLY_W-1:0] tap_sel,
   output logic                      strb_out
);

   logic [PIO_DLY_N-1:0] stage_r;

   // Each stage adds one clock of delay; stage 0 is the first one.
   for (genvar i = 0; i < PIO_DLY_N; i++) begin : g_stage
      always_ff @(posedge clk) begin
         if (rst) begin
            stage_r[i] <= 1'b0;
         end else if (i == 0) begin
            stage_r[i] <= strb_in;
         end else begin
            stage_r[i] <= stage_r[(i == 0) ? 0 : i-1];
         end
      end
   end

   // The tap is picked from flops, so the output never glitches.
   assign strb_out = stage_r[tap_sel];

endmodule // pio_strb_dly

// *** rtl/pio_ctl_sel.sv ***
// Control logic: picks and inverts clock, enable and reset for the cell.
`timescale 1ns/1ps
module pio_ctl_sel
   import pio_pkg::*;
(
   input  wire logic [PIO_RCLK_N-1:0] rt_clk,
   input  wire logic                  strb_dly,
   input  wire logic                  rt_ce,
   input  wire logic                  rt_lsr,
   input  wire logic                  gts_in,
   input  wire pio_cfg_t              cfg,
   output pio_ctl_t                   ctl
);

   logic clk_src;

   // Strobe is only a choice on cells that own a strobe pad.
   always_comb begin
      if (cfg.src_strb && PIO_STRB_AVAIL) begin
         clk_src = strb_dly;
      end else begin
         clk_src = rt_clk[cfg.rclk_sel];
      end
   end

   // Optional inversions; the global tristate is passed on untouched.
   assign ctl.cell_clk = clk_src ^ cfg.clk_inv;
   assign ctl.cell_ce  = rt_ce ^ cfg.ce_inv;
   assign ctl.cell_lsr = rt_lsr ^ cfg.lsr_inv;
   assign ctl.gts      = gts_in;

endmodule // pio_ctl_sel

// *** rtl/pio_out_reg.sv ***
// Output register block of one I/O cell with control logic and APB access.
`timescale 1ns/1ps
module pio_out_reg
   import pio_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [PIO_ADDR_W-1:0] paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic [PIO_RCLK_N-1:0] rt_clk,
   input  wire logic                  strb_pad,
   input  wire logic                  rt_ce,
   input  wire logic                  rt_lsr,
   input  wire logic                  gts_in,
   input  wire logic                  out_data_first,
   input  wire logic                  out_data_second,
   output logic                       pad_out_data,
   output logic                       pad_tristate
);

   pio_cfg_t  cfg_r;
   pio_ctl_t  ctl;
   logic      strb_s1_r;
   logic      strb_s2_r;
   logic      strb_dly_o;
   logic      cclk_d_r;
   logic      cclk_rise;
   logic      first_r;
   logic      second_r;
   logic      pad_r;
   logic      pad_nxt;
   logic      first_load;
   logic [31:0] rd_nxt;
   logic      err_nxt;
   logic [31:0] prdata_r;
   logic      pslverr_r;
   logic      acc_wr;
   logic      setup;

   // ------------------------------------------------------------------
   // APB slave.
   // ------------------------------------------------------------------

   // Every access ends in its first access cycle; no wait states.
   assign pready = 1'b1;
   assign setup  = psel && !penable;
   assign acc_wr = psel && penable && pwrite;

   // Read data is decoded in the setup cycle so that it can be held in a
   // flop during the access cycle; status therefore lags by one clock.
   always_comb begin
      rd_nxt  = 32'h0000_0000;
      err_nxt = 1'b0;
      case (paddr)
         PIO_CTRL_OFS: begin
            rd_nxt[PIO_CFG_W-1:0] = cfg_r;
         end
         PIO_STAT_OFS: begin
            rd_nxt[PIO_ST_PAD]    = pad_r;
            rd_nxt[PIO_ST_CCLK]   = ctl.cell_clk;
            rd_nxt[PIO_ST_FIRST]  = first_r;
            rd_nxt[PIO_ST_SECOND] = second_r;
            rd_nxt[PIO_ST_GTS]    = ctl.gts;
            rd_nxt[PIO_ST_CE]     = ctl.cell_ce;
            rd_nxt[PIO_ST_LSR]    = ctl.cell_lsr;
            err_nxt               = pwrite;
         end
         default: begin
            err_nxt = 1'b1;
         end
      endcase
   end

   // Answer flops, loaded in the setup cycle of each transfer.
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (setup) begin
         prdata_r  <= pwrite ? 32'h0000_0000 : rd_nxt;
         pslverr_r <= err_nxt;
      end
   end

   assign prdata  = prdata_r;
   assign pslverr = pslverr_r;

   // Control register; only the low field bits are stored, the rest read 0.
   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_r <= pio_cfg_t'(PIO_CTRL_RST[PIO_CFG_W-1:0]);
      end else if (acc_wr && paddr == PIO_CTRL_OFS) begin
         cfg_r <= pio_cfg_t'(pwdata[PIO_CFG_W-1:0]);
      end
   end

   // ------------------------------------------------------------------
   // Strobe path and control logic.
   // ------------------------------------------------------------------

   // The strobe arrives from a pad, so it is synchronised before use.
   always_ff @(posedge clk) begin
      if (rst) begin
         strb_s1_r <= 1'b0;
         strb_s2_r <= 1'b0;
      end else begin
         strb_s1_r <= strb_pad;
         strb_s2_r <= strb_s1_r;
      end
   end

   // Delay element between the strobe pad and its clock routing.
   pio_strb_dly u_dly (
      .clk      (clk),
      .rst      (rst),
      .strb_in  (strb_s2_r),
      .tap_sel  (cfg_r.strb_dly),
      .strb_out (strb_dly_o)
   );

   // Selection and inversion of clock, enable and local reset.
   pio_ctl_sel u_ctl (
      .rt_clk   (rt_clk),
      .strb_dly (strb_dly_o),
      .rt_ce    (rt_ce),
      .rt_lsr   (rt_lsr),
      .gts_in   (gts_in),
      .cfg      (cfg_r),
      .ctl      (ctl)
   );

   // ------------------------------------------------------------------
   // Output register block.
   // ------------------------------------------------------------------

   // The cell clock is a level sampled by clk; its rising edge is found
   // by comparing with last cycle. Cell clocks must stay below clk/2.
   always_ff @(posedge clk) begin
      if (rst) begin
         cclk_d_r <= 1'b0;
      end else begin
         cclk_d_r <= ctl.cell_clk;
      end
   end

   assign cclk_rise = ctl.cell_clk && !cclk_d_r;

   // Latch mode applies to SDR only; DDR always wants the edge flop.
   always_comb begin
      if (cfg_r.sdr_latch && !cfg_r.ddr) begin
         first_load = ctl.cell_clk;
      end else begin
         first_load = cclk_rise;
      end
   end

   // SDR register: local reset wins over the enable, as in the fabric.
   always_ff @(posedge clk) begin
      if (rst || ctl.cell_lsr) begin
         first_r <= 1'b0;
      end else if (ctl.cell_ce && first_load) begin
         first_r <= out_data_first;
      end
   end

   // Extra DDR latch: open while the clock is high, so it holds the value
   // from the falling edge while the clock is low. Only the global reset
   // touches it, for a defined power-up value.
   always_ff @(posedge clk) begin
      if (rst) begin
         second_r <= 1'b0;
      end else if (ctl.cell_clk) begin
         second_r <= out_data_second;
      end
   end

   // Pad mux; in SDR only the first element ever reaches the pad.
   always_comb begin
      if (cfg_r.ddr) begin
         pad_nxt = ctl.cell_clk ? first_r : second_r;
      end else begin
         pad_nxt = first_r;
      end
   end

   // The pad value leaves from a flop to keep the pad buffer glitch free.
   always_ff @(posedge clk) begin
      if (rst) begin
         pad_r <= 1'b0;
      end else begin
         pad_r <= pad_nxt;
      end
   end

   assign pad_out_data = pad_r;
   assign pad_tristate = ctl.gts;

   // ------------------------------------------------------------------
   // Checks.
   // ------------------------------------------------------------------

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // A control write in its access cycle.
   sequence ctrl_wr_s;
      psel && penable && pwrite && paddr == PIO_CTRL_OFS;
   endsequence

   // A fresh setup cycle aimed at the status register.
   sequence stat_rd_s;
      psel && !penable && !pwrite && paddr == PIO_STAT_OFS;
   endsequence

   // A DDR rising edge with the enable open and no local reset.
   sequence ddr_edge_s;
      cfg_r.ddr && cclk_rise && ctl.cell_ce && !ctl.cell_lsr;
   endsequence

   // A setup cycle at an address that no register decodes.
   sequence bad_addr_s;
      psel && !penable && paddr != PIO_CTRL_OFS && paddr != PIO_STAT_OFS;
   endsequence

   ctrl_write_a: assert property (
      ctrl_wr_s |=> cfg_r == $past(pwdata[PIO_CFG_W-1:0]))
      else $error("Control write not stored.");

   stat_read_a: assert property (
      stat_rd_s |=> prdata[PIO_ST_PAD] == $past(pad_r) && !pslverr)
      else $error("Status read lost the pad value.");

   sdr_capture_a: assert property (
      !cfg_r.ddr && !cfg_r.sdr_latch && cclk_rise && ctl.cell_ce
      && !ctl.cell_lsr |=> first_r == $past(out_data_first)
      ##1 (cfg_r.ddr || pad_out_data == $past(first_r)))
      else $error("SDR flop did not reach the pad.");

   latch_follow_a: assert property (
      !cfg_r.ddr && cfg_r.sdr_latch && ctl.cell_clk && ctl.cell_ce
      && !ctl.cell_lsr |=> first_r == $past(out_data_first))
      else $error("SDR latch not transparent.");

   flop_hold_a: assert property (
      !cfg_r.sdr_latch && !cclk_rise && !ctl.cell_lsr
      |=> $stable(first_r))
      else $error("Edge flop moved without an edge.");

   ddr_first_a: assert property (
      ddr_edge_s |=> first_r == $past(out_data_first))
      else $error("DDR first data not caught on rise.");

   second_hold_a: assert property (
      !ctl.cell_clk |=> $stable(second_r))
      else $error("DDR latch moved while clock low.");

   second_open_a: assert property (
      ctl.cell_clk |=> second_r == $past(out_data_second))
      else $error("DDR latch ignored data while open.");

   mux_high_a: assert property (
      cfg_r.ddr && ctl.cell_clk |=> pad_out_data == $past(first_r))
      else $error("DDR mux wrong while clock high.");

   mux_low_a: assert property (
      cfg_r.ddr && !ctl.cell_clk |=> pad_out_data == $past(second_r))
      else $error("DDR mux wrong while clock low.");

   lsr_clear_a: assert property (
      ctl.cell_lsr |=> !first_r ##1 (cfg_r.ddr || !pad_out_data))
      else $error("Local reset did not clear output.");

   ce_hold_a: assert property (
      !ctl.cell_ce && !ctl.cell_lsr |=> $stable(first_r))
      else $error("SDR register moved with enable off.");

   clk_pick_a: assert property (
      ctl.cell_clk == ((cfg_r.src_strb ? strb_dly_o
                        : rt_clk[cfg_r.rclk_sel]) ^ cfg_r.clk_inv))
      else $error("Cell clock selection wrong.");

   ctl_inv_a: assert property (
      ctl.cell_ce == (rt_ce ^ cfg_r.ce_inv)
      && ctl.cell_lsr == (rt_lsr ^ cfg_r.lsr_inv))
      else $error("Enable or reset inversion wrong.");

   gts_pass_a: assert property (
      pad_tristate == gts_in)
      else $error("Global tristate altered.");

   // Two sync flops plus tap+1 stages: tap 0 lags the pad by three clocks.
   strb_min_a: assert property (
      cfg_r.strb_dly == 3'h0 && $stable(cfg_r.strb_dly)
      |-> strb_dly_o == $past(strb_pad, 3))
      else $error("Strobe delay at tap 0 wrong.");

   strb_max_a: assert property (
      cfg_r.strb_dly == 3'h7 && $stable(cfg_r.strb_dly)
      |-> strb_dly_o == $past(strb_pad, 10))
      else $error("Strobe delay at tap 7 wrong.");

   // Refusals and the write path of the register bus.
   ctrl_keep_a: assert property (
      !(psel && penable && pwrite && paddr == PIO_CTRL_OFS)
      |=> $stable(cfg_r))
      else $error("Control changed without a write.");

   stat_err_a: assert property (
      psel && !penable && pwrite && paddr == PIO_STAT_OFS |=> pslverr)
      else $error("Status write not refused.");

   bad_addr_a: assert property (
      bad_addr_s |=> pslverr && prdata == 32'h0000_0000)
      else $error("Unmapped access not refused.");

   // In SDR the pad follows the first element and nothing else.
   sdr_pad_a: assert property (
      !cfg_r.ddr |=> pad_out_data == $past(first_r))
      else $error("SDR pad not fed by first element.");

   // Local reset must beat an open enable on a load cycle.
   lsr_win_a: assert property (
      ctl.cell_lsr && ctl.cell_ce && first_load |=> !first_r)
      else $error("Enable overrode local reset.");

endmodule // pio_out_reg

// *** test/pio_fabric_model.sv ***
// Fabric and strobe pad stand-in that drives the cell clock sources.
`timescale 1ns/1ps
module pio_fabric_model
   import pio_pkg::*;
#(
   parameter int HALF = 8
)
(
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic [1:0]            line,
   input  wire logic                  use_strb,
   output logic      [PIO_RCLK_N-1:0] rt_clk,
   output logic                       strb_pad,
   output logic                       phase_hi,
   output logic      [3:0]            ph_cnt
);
   // Slow square wave, so each phase spans several fabric cycles.
   always_ff @(posedge clk) begin
      if (rst) begin
         ph_cnt   <= 4'h0;
         phase_hi <= 1'b0;
      end else if (ph_cnt == 4'(HALF - 1)) begin
         ph_cnt   <= 4'h0;
         phase_hi <= ~phase_hi;
      end else begin
         ph_cnt <= ph_cnt + 4'h1;
      end
   end

   // Only the chosen source toggles; the others stay low, so a wrong
   // selection shows up as a missing update. The pad strobe idles low.
   always_comb begin
      rt_clk       = '0;
      rt_clk[line] = phase_hi & ~use_strb;
      strb_pad     = phase_hi & use_strb;
   end
endmodule // pio_fabric_model

// *** test/pio_out_reg_tb.sv ***
// Self-checking bench for the I/O cell output register block.
`timescale 1ns/1ps
module pio_out_reg_tb;
   import pio_pkg::*;

   localparam int HALF = 8;

   // Bits of v: strobe, ce, lsr, first, second, pad high, pad low.
   typedef struct packed {
      logic [10:0] cfg;
      logic [1:0]  line;
      logic [6:0]  v;
   } pio_row_t;

   logic                  clk = 1'b0;
   logic                  rst;
   logic                  psel;
   logic                  penable;
   logic                  pwrite;
   logic [PIO_ADDR_W-1:0] paddr;
   logic [31:0]           pwdata;
   logic [31:0]           prdata;
   logic                  pready;
   logic                  pslverr;
   logic [PIO_RCLK_N-1:0] rt_clk;
   logic                  strb_pad;
   logic                  rt_ce;
   logic                  rt_lsr;
   logic                  gts_in;
   logic                  out_data_first;
   logic                  out_data_second;
   logic                  pad_out_data;
   logic                  pad_tristate;
   logic [1:0]            line;
   logic                  use_strb;
   logic                  phase_hi;
   logic [3:0]            ph_cnt;
   logic [31:0]           rd;
   logic                  err;
   int                    errors = 0;
   int                    comparisons = 0;

   // Hold rows are ordered so the previous pad value is known.
   pio_row_t rows [16] = '{
      '{11'h000, 2'h0, 7'b0101011},
      '{11'h000, 2'h0, 7'b0000011},
      '{11'h000, 2'h0, 7'b0111000},
      '{11'h001, 2'h0, 7'b0101010},
      '{11'h001, 2'h0, 7'b0100101},
      '{11'h021, 2'h0, 7'b0101001},
      '{11'h001, 2'h0, 7'b0011101},
      '{11'h008, 2'h2, 7'b0101011},
      '{11'h008, 2'h1, 7'b0100011},
      '{11'h040, 2'h0, 7'b0000000},
      '{11'h040, 2'h0, 7'b0101000},
      '{11'h000, 2'h0, 7'b0101011},
      '{11'h080, 2'h0, 7'b0101000},
      '{11'h080, 2'h0, 7'b0111011},
      '{11'h010, 2'h0, 7'b1100000},
      '{11'h710, 2'h0, 7'b1101011}
   };

   always #10 clk = ~clk;

   pio_out_reg i_pio_out_reg (
      .clk             (clk),
      .rst             (rst),
      .psel            (psel),
      .penable         (penable),
      .pwrite          (pwrite),
      .paddr           (paddr),
      .pwdata          (pwdata),
      .prdata          (prdata),
      .pready          (pready),
      .pslverr         (pslverr),
      .rt_clk          (rt_clk),
      .strb_pad        (strb_pad),
      .rt_ce           (rt_ce),
      .rt_lsr          (rt_lsr),
      .gts_in          (gts_in),
      .out_data_first  (out_data_first),
      .out_data_second (out_data_second),
      .pad_out_data    (pad_out_data),
      .pad_tristate    (pad_tristate)
   );

   pio_fabric_model #(.HALF(HALF)) i_pio_fabric_model (
      .clk      (clk),
      .rst      (rst),
      .line     (line),
      .use_strb (use_strb),
      .rt_clk   (rt_clk),
      .strb_pad (strb_pad),
      .phase_hi (phase_hi),
      .ph_cnt   (ph_cnt)
   );

   task automatic check(input logic [31:0] got, input logic [31:0] exp,
                        input string msg);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   // One-bit compare, widened on purpose for the common check.
   task automatic check_bit(input logic got, input logic exp,
                            input string msg);
      check({31'h0, got}, {31'h0, exp}, msg);
   endtask

   // One APB transfer; the request stands until pready is seen high.
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Bounded wait for a given cycle of a given cell clock phase.
   task automatic wait_ph(input logic hi, input logic [3:0] cnt);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (!(phase_hi === hi && ph_cnt === cnt) && n < 100);
      if (!(phase_hi === hi && ph_cnt === cnt)) begin
         errors++;
         $display("ERROR %0t cell clock phase never reached", $time);
      end
   endtask

   task automatic run_row(input pio_row_t r);
      apb(1'b1, PIO_CTRL_OFS, {21'h0, r.cfg});
      line            <= r.line;
      use_strb        <= r.v[6];
      rt_ce           <= r.v[5];
      rt_lsr          <= r.v[4];
      out_data_first  <= r.v[3];
      out_data_second <= r.v[2];
      wait_ph(1'b1, 4'(HALF - 1));
      wait_ph(1'b0, 4'(HALF - 1));
      wait_ph(1'b1, 4'(HALF - 1));
      check_bit(pad_out_data, r.v[1], "pad in high phase");
      wait_ph(1'b0, 4'(HALF - 1));
      check_bit(pad_out_data, r.v[0], "pad in low phase");
   endtask

   task automatic conclude();
      if (errors == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Main sequence: register access, table rows, then awkward cases.
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      rt_ce = 1'b0;
      rt_lsr = 1'b0;
      gts_in = 1'b0;
      out_data_first = 1'b0;
      out_data_second = 1'b0;
      line = 2'h0;
      use_strb = 1'b0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      check_bit(pad_out_data, 1'b0, "pad after reset");
      apb(1'b0, PIO_CTRL_OFS, 32'h0);
      check(rd, PIO_CTRL_RST, "ctrl reset value");
      apb(1'b1, PIO_CTRL_OFS, 32'hffff_ffff);
      apb(1'b0, PIO_CTRL_OFS, 32'h0);
      check(rd, 32'h0000_07ff, "ctrl readback");
      apb(1'b0, 12'h008, 32'h0);
      check(rd, 32'h0000_0000, "unmapped read");
      check_bit(err, 1'b1, "unmapped read error");
      apb(1'b1, PIO_STAT_OFS, 32'hffff_ffff);
      check_bit(err, 1'b1, "status write");
      for (int i = 0; i < 16; i++) begin
         run_row(rows[i]);
      end
      // A latch passes data mid-phase; a flop waits for the next edge.
      for (int m = 0; m < 2; m++) begin
         apb(1'b1, PIO_CTRL_OFS, {30'h0, m[0], 1'b0});
         line <= 2'h0;
         use_strb <= 1'b0;
         rt_lsr <= 1'b0;
         out_data_first <= 1'b0;
         wait_ph(1'b0, 4'h1);
         wait_ph(1'b1, 4'h1);
         @(posedge clk);
         out_data_first <= 1'b1;
         repeat (2) @(posedge clk);
         #1;
         check_bit(pad_out_data, m[0], "latch or flop mode");
      end
      // The global tristate passes straight through.
      for (int g = 0; g < 2; g++) begin
         @(posedge clk);
         gts_in <= g[0];
         apb(1'b0, PIO_STAT_OFS, 32'h0);
         check_bit(pad_tristate, g[0], "tristate pin");
         check_bit(rd[PIO_ST_GTS], g[0], "tristate status");
      end
      // Second reset in mid-run clears pad and control.
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1;
      check_bit(pad_out_data, 1'b0, "pad after second reset");
      apb(1'b0, PIO_CTRL_OFS, 32'h0);
      check(rd, PIO_CTRL_RST, "ctrl after second reset");
      conclude();
   end

   // Watchdog far beyond the expected run of under a thousand cycles.
   initial begin
      #1_000_000;
      errors++;
      $display("ERROR %0t watchdog ran out", $time);
      conclude();
   end
endmodule // pio_out_reg_tb
